// *** design/scc_coproc.sv ***
/*
 system control coprocessor register map with access decode and base-restored abort tracking.
 assumes the core presents one decoded coprocessor request per cycle, synchronous to core_clk.
*/
// Summary of operation
// R1 - registers are reached only by register transfer instructions, reads return and writes store.
// R2 - a transfer whose condition fails reads and writes nothing.
// R3 - on a data abort the base register is restored to its value before the instruction.
// R4 - primary 0 gives identification, cache type and memory size views by secondary opcode, writes ignored.
// R5 - primaries 2, 5 and 9 keep separate instruction and data copies chosen by the secondary fields.
// R6 - primary 7 takes writes as cache commands and reads back zero.
// R7 - primary 1 is a read-write control word that includes the endianness select.
// R8 - primary 6 holds one base-and-size word per region chosen by the secondary register field.
// R9 - primary 13 is a read-write trace context word driven to the trace logic.
// R10 - primary 15 holds self-test, test state, debug pointer and trace control words.
// R11 - primary 3 is a read-write write buffer control word.
// R12 - unassigned primaries read zero and ignore writes.
// R13 - unprivileged transfers and any non-transfer instruction to this unit trap as undefined.
// R14 - reset clears all state except the high-vector and instruction memory enable bits taken from pins.
`timescale 1ns/10ps
`include "scc_params.svh"
module scc_coproc
    import scc_pkg::*;
#(
    parameter logic [31:0] DEVICE_ID = 32'h0000_0001,  // arbitrary value
    parameter logic [31:0] CACHE_TYPE = 32'h0000_0000,
    parameter logic [31:0] LOCAL_MEM_SIZE = 32'h0000_0000,
    parameter int NUM_REGIONS = 8
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire scc_req_s req,
    output scc_rsp_s rsp,
    input wire logic high_vector_init_pin,
    input wire logic instr_memory_enable_init_pin,
    input wire logic mem_instr_start,
    input wire logic [31:0] mem_base_before,
    input wire logic mem_instr_done,
    input wire logic data_abort,
    output logic base_restore_valid,
    output logic [31:0] base_restore_value,
    output logic [31:0] system_control,
    output logic big_endian,
    output logic [1:0][31:0] cacheability,
    output logic [31:0] bufferability,
    output logic [1:0][31:0] permissions,
    output logic [NUM_REGIONS-1:0][31:0] regions,
    output logic [1:0][31:0] way_lock,
    output logic [1:0][31:0] local_mem_region,
    output logic [31:0] trace_context_id,
    output logic [31:0] memory_self_test,
    output logic [31:0] test_state,
    output logic [31:0] cache_debug_pointer,
    output logic [31:0] trace_control,
    output scc_cache_cmd_s cache_cmd
);
    localparam int IDX_W = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;

    // side select of paired registers: low secondary opcode bit picks instruction side
    function automatic logic side_of(input logic [2:0] opc2);
        return opc2[0];
    endfunction

    // primary 15 selector: returns one-hot of self test, test state, debug pointer, trace ctrl
    function automatic logic [3:0] test_sel(input logic [3:0] sec, input logic [2:0] opc2);
        logic [3:0] s;
        s = 4'h0;
        if ((sec == `SCC_SEC_TEST_B) && (opc2 == 3'h0))
        begin
            s = 4'h1;
        end
        else if ((sec == `SCC_SEC_TEST_A) && (opc2 == 3'h0))
        begin
            s = 4'h2;
        end
        else if ((sec == `SCC_SEC_TEST_A) && (opc2 == 3'h1))
        begin
            s = 4'h4;
        end
        else if ((sec == `SCC_SEC_TEST_B) && (opc2 == 3'h1))
        begin
            s = 4'h8;
        end
        return s;
    endfunction

    logic trap;
    logic go;
    logic wr;
    logic rd;
    logic [3:0] tsel;
    logic [31:0] rd_word;
    logic [31:0] region_rd;
    logic [31:0] ctrl_q;
    logic init_done_q;
    logic [31:0] cacheable_q [2];
    logic [31:0] perm_q [2];
    logic [31:0] lock_q [2];
    logic [31:0] loc_region_q [2];
    logic [31:0] buffer_q;
    logic [31:0] trace_id_q;
    logic [31:0] self_test_q;
    logic [31:0] test_state_q;
    logic [31:0] debug_ptr_q;
    logic [31:0] trace_ctrl_q;
    scc_rsp_s rsp_q;
    scc_cache_cmd_s cmd_q;
    scc_abort_e ab_state_q;
    logic [31:0] saved_base_q;
    logic restore_valid_q;
    logic [31:0] restore_value_q;

    assign trap = req.valid && (!req.is_reg_xfer || !req.privileged); // R13
    assign go = req.valid && req.is_reg_xfer && req.privileged && req.cond_pass; // R1 R2
    assign wr = go && !req.is_read; // R1
    assign rd = go && req.is_read; // R1
    assign tsel = test_sel(req.sec, req.opc2);

    scc_region_bank #(
        .NUM_REGIONS(NUM_REGIONS),
        .IDX_W(IDX_W)
    ) u_regions (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .wr_en(wr && (req.pri == `SCC_PRI_REGION)),
        .wr_idx(req.sec[IDX_W-1:0]),
        .wr_data(req.wdata),
        .rd_idx(req.sec[IDX_W-1:0]),
        .rd_data(region_rd),
        .regions(regions)
    );

    // control word, pin-loaded bits caught on the first edge after release
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= `SCC_RESET_WORD; // R14
            init_done_q <= 1'b0;
        end
        else if (!init_done_q)
        begin
            init_done_q <= 1'b1;
            ctrl_q[`SCC_CTRL_HIVEC_BIT] <= high_vector_init_pin; // R14
            ctrl_q[`SCC_CTRL_IMEM_EN_BIT] <= instr_memory_enable_init_pin; // R14
        end
        else if (wr && (req.pri == `SCC_PRI_CTRL))
        begin
            ctrl_q <= req.wdata; // R7
        end
    end

    genvar s;
    generate
        for (s = 0; s < 2; s++)
        begin : g_side
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    cacheable_q[s] <= `SCC_RESET_WORD;
                    perm_q[s] <= `SCC_RESET_WORD;
                    lock_q[s] <= `SCC_RESET_WORD;
                    loc_region_q[s] <= `SCC_RESET_WORD; // R14
                end
                else if (wr && (side_of(req.opc2) == 1'(s)))
                begin
                    if (req.pri == `SCC_PRI_CACHEABLE)
                    begin
                        cacheable_q[s] <= req.wdata; // R5
                    end
                    if (req.pri == `SCC_PRI_PERM)
                    begin
                        perm_q[s] <= req.wdata; // R5
                    end
                    if ((req.pri == `SCC_PRI_LOCK_LOC) && (req.sec == `SCC_SEC_LOCK))
                    begin
                        lock_q[s] <= req.wdata; // R5
                    end
                    if ((req.pri == `SCC_PRI_LOCK_LOC) && (req.sec == `SCC_SEC_LOC_REGION))
                    begin
                        loc_region_q[s] <= req.wdata; // R5
                    end
                end
            end
            assign cacheability[s] = cacheable_q[s];
            assign permissions[s] = perm_q[s];
            assign way_lock[s] = lock_q[s];
            assign local_mem_region[s] = loc_region_q[s];
        end
    endgenerate

    // single-word registers at primaries 3 and 13
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            buffer_q <= `SCC_RESET_WORD;
            trace_id_q <= `SCC_RESET_WORD; // R14
        end
        else if (wr)
        begin
            if (req.pri == `SCC_PRI_BUFFERABLE)
            begin
                buffer_q <= req.wdata; // R11
            end
            if (req.pri == `SCC_PRI_TRACE_ID)
            begin
                trace_id_q <= req.wdata; // R9
            end
        end
    end

    // test and debug words at primary 15
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            self_test_q <= `SCC_RESET_WORD;
            test_state_q <= `SCC_RESET_WORD;
            debug_ptr_q <= `SCC_RESET_WORD;
            trace_ctrl_q <= `SCC_RESET_WORD; // R14
        end
        else if (wr && (req.pri == `SCC_PRI_TEST))
        begin
            if (tsel[0])
            begin
                self_test_q <= req.wdata; // R10
            end
            if (tsel[1])
            begin
                test_state_q <= req.wdata; // R10
            end
            if (tsel[2])
            begin
                debug_ptr_q <= req.wdata; // R10
            end
            if (tsel[3])
            begin
                trace_ctrl_q <= req.wdata; // R10
            end
        end
    end

    // read multiplexer
    always_comb
    begin
        rd_word = 32'h0000_0000; // R12
        if (req.pri == `SCC_PRI_IDENT)
        begin
            if (req.opc2 == `SCC_OP2_CACHE_TYPE)
            begin
                rd_word = CACHE_TYPE; // R4
            end
            else if (req.opc2 == `SCC_OP2_LOC_SIZE)
            begin
                rd_word = LOCAL_MEM_SIZE; // R4
            end
            else
            begin
                rd_word = DEVICE_ID; // R4
            end
        end
        else if (req.pri == `SCC_PRI_CTRL)
        begin
            rd_word = ctrl_q; // R7
        end
        else if (req.pri == `SCC_PRI_CACHEABLE)
        begin
            rd_word = cacheable_q[side_of(req.opc2)]; // R5
        end
        else if (req.pri == `SCC_PRI_BUFFERABLE)
        begin
            rd_word = buffer_q; // R11
        end
        else if (req.pri == `SCC_PRI_PERM)
        begin
            rd_word = perm_q[side_of(req.opc2)]; // R5
        end
        else if (req.pri == `SCC_PRI_REGION)
        begin
            rd_word = region_rd; // R8
        end
        else if (req.pri == `SCC_PRI_CACHE_OP)
        begin
            rd_word = 32'h0000_0000; // R6
        end
        else if (req.pri == `SCC_PRI_LOCK_LOC)
        begin
            if (req.sec == `SCC_SEC_LOC_REGION)
            begin
                rd_word = loc_region_q[side_of(req.opc2)]; // R5
            end
            else if (req.sec == `SCC_SEC_LOCK)
            begin
                rd_word = lock_q[side_of(req.opc2)]; // R5
            end
        end
        else if (req.pri == `SCC_PRI_TRACE_ID)
        begin
            rd_word = trace_id_q; // R9
        end
        else if (req.pri == `SCC_PRI_TEST)
        begin
            if (tsel[0])
            begin
                rd_word = self_test_q; // R10
            end
            else if (tsel[1])
            begin
                rd_word = test_state_q;
            end
            else if (tsel[2])
            begin
                rd_word = debug_ptr_q;
            end
            else if (tsel[3])
            begin
                rd_word = trace_ctrl_q;
            end
        end
    end

    // answer to the core one cycle after the request
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q.valid <= req.valid;
            rsp_q.undef_trap <= trap; // R13
            if (rd)
            begin
                rsp_q.rdata <= rd_word; // R1
            end
        end
    end

    // cache maintenance command pulse
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmd_q <= '0;
        end
        else
        begin
            cmd_q.valid <= wr && (req.pri == `SCC_PRI_CACHE_OP); // R6
            if (wr && (req.pri == `SCC_PRI_CACHE_OP))
            begin
                cmd_q.sec <= req.sec;
                cmd_q.opc2 <= req.opc2;
                cmd_q.data <= req.wdata; // R6
            end
        end
    end

    // base-restored abort tracking
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ab_state_q <= SCC_AB_IDLE;
            saved_base_q <= `SCC_RESET_WORD;
            restore_valid_q <= 1'b0;
            restore_value_q <= `SCC_RESET_WORD;
        end
        else
        begin
            restore_valid_q <= 1'b0;
            case (ab_state_q)
                SCC_AB_IDLE:
                begin
                    if (mem_instr_start)
                    begin
                        saved_base_q <= mem_base_before; // R3
                        ab_state_q <= SCC_AB_ARMED;
                    end
                end
                SCC_AB_ARMED:
                begin
                    if (data_abort)
                    begin
                        restore_valid_q <= 1'b1;
                        restore_value_q <= saved_base_q; // R3
                        ab_state_q <= SCC_AB_IDLE;
                    end
                    else if (mem_instr_done)
                    begin
                        ab_state_q <= SCC_AB_IDLE;
                    end
                end
                default:
                begin
                    ab_state_q <= SCC_AB_IDLE;
                end
            endcase
        end
    end

    assign rsp = rsp_q;
    assign cache_cmd = cmd_q;
    assign base_restore_valid = restore_valid_q;
    assign base_restore_value = restore_value_q;
    assign system_control = ctrl_q;
    assign big_endian = ctrl_q[`SCC_CTRL_BIG_END_BIT]; // R7
    assign bufferability = buffer_q;
    assign trace_context_id = trace_id_q; // R9
    assign memory_self_test = self_test_q;
    assign test_state = test_state_q;
    assign cache_debug_pointer = debug_ptr_q;
    assign trace_control = trace_ctrl_q;
endmodule // scc_coproc

// *** common/scc_params.svh ***
/*
 system control coprocessor constants: primary numbers, selectors, reset values, bit positions.
 assumes inclusion from the package and design files by bare name.
*/
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
`define SCC_PRI_IDENT 4'h0
`define SCC_PRI_CTRL 4'h1
`define SCC_PRI_CACHEABLE 4'h2
`define SCC_PRI_BUFFERABLE 4'h3
`define SCC_PRI_PERM 4'h5
`define SCC_PRI_REGION 4'h6
`define SCC_PRI_CACHE_OP 4'h7
`define SCC_PRI_LOCK_LOC 4'h9
`define SCC_PRI_TRACE_ID 4'hd
`define SCC_PRI_TEST 4'hf
`define SCC_OP2_CACHE_TYPE 3'h1
`define SCC_OP2_LOC_SIZE 3'h2
`define SCC_SEC_LOCK 4'h0
`define SCC_SEC_LOC_REGION 4'h1
`define SCC_SEC_TEST_A 4'h0
`define SCC_SEC_TEST_B 4'h1
`define SCC_CTRL_HIVEC_BIT 13
`define SCC_CTRL_IMEM_EN_BIT 18
`define SCC_CTRL_BIG_END_BIT 7
`define SCC_RESET_WORD 32'h0000_0000
`define SCC_SIDE_DATA 1'b0
`define SCC_SIDE_INSTR 1'b1
`endif

// *** common/scc_pkg.sv ***
/*
 types of the system control coprocessor: request and answer structs, abort tracker states.
 assumes scc_params.svh is on the include path.
*/
package scc_pkg;
`include "scc_params.svh"
    typedef struct packed {
        logic valid;
        logic is_reg_xfer;
        logic is_read;
        logic cond_pass;
        logic privileged;
        logic [2:0] opc1;
        logic [3:0] pri;
        logic [3:0] sec;
        logic [2:0] opc2;
        logic [31:0] wdata;
    } scc_req_s;

    typedef struct packed {
        logic valid;
        logic undef_trap;
        logic [31:0] rdata;
    } scc_rsp_s;

    typedef struct packed {
        logic valid;
        logic [3:0] sec;
        logic [2:0] opc2;
        logic [31:0] data;
    } scc_cache_cmd_s;

    typedef enum logic [1:0] {
        SCC_AB_IDLE = 2'b01,
        SCC_AB_ARMED = 2'b10
    } scc_abort_e;
endpackage

// *** design/scc_region_bank.sv ***
/*
 bank of protection region base-and-size words, one per region.
 assumes writes are already qualified by the caller; read is combinational.
*/
`timescale 1ns/10ps
`include "scc_params.svh"
module scc_region_bank
    import scc_pkg::*;
#(
    parameter int NUM_REGIONS = 8,
    parameter int IDX_W = 3
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [31:0] rd_data,
    output logic [NUM_REGIONS-1:0][31:0] regions
);
    logic [31:0] region_q [NUM_REGIONS];

    genvar g;
    generate
        for (g = 0; g < NUM_REGIONS; g++)
        begin : g_region
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    region_q[g] <= `SCC_RESET_WORD; // R14
                end
                else if (wr_en && (wr_idx == IDX_W'(g)))
                begin
                    region_q[g] <= wr_data; // R8
                end
            end
            assign regions[g] = region_q[g];
        end
    endgenerate

    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (int'(rd_idx) < NUM_REGIONS)
        begin
            rd_data = region_q[rd_idx]; // R8
        end
    end
endmodule // scc_region_bank

// *** dv/scc_coproc_properties.sv ***
/*
 concurrent checks on the system control coprocessor ports, bound into scc_coproc.
 assumes the one-cycle answer and reset pin load described for the core request port.
*/
`timescale 1ns/10ps
module scc_coproc_properties
    import scc_pkg::*;
#(
    parameter logic [31:0] CACHE_TYPE = 32'h0000_0000
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire scc_req_s req,
    input wire scc_rsp_s rsp,
    input wire logic high_vector_init_pin,
    input wire logic instr_memory_enable_init_pin,
    input wire logic mem_instr_start,
    input wire logic [31:0] mem_base_before,
    input wire logic data_abort,
    input wire logic base_restore_valid,
    input wire logic [31:0] base_restore_value,
    input wire logic [31:0] system_control,
    input wire logic big_endian,
    input wire logic [31:0] bufferability,
    input wire scc_cache_cmd_s cache_cmd
);
    logic eff;
    assign eff = req.valid & req.is_reg_xfer & req.privileged & req.cond_pass;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_armed_abort;
        mem_instr_start ##1 data_abort;
    endsequence
    sequence s_restored;
        base_restore_valid && base_restore_value == $past(mem_base_before, 2) ##1 !base_restore_valid;
    endsequence
    chk_rsp_follows_req: assert property (req.valid |=> rsp.valid)
        else $error("no answer one cycle after a request");
    chk_rsp_needs_req: assert property (!req.valid |=> !rsp.valid)
        else $error("answer without a request");
    chk_trap_unpriv: assert property (req.valid && (!req.privileged || !req.is_reg_xfer)
        |=> rsp.undef_trap)
        else $error("refused instruction did not trap");
    chk_cond_fail_quiet: assert property (req.valid && req.is_reg_xfer && req.privileged
        && !req.cond_pass |=> !rsp.undef_trap && $stable(rsp.rdata) && $stable(bufferability))
        else $error("failed condition changed state");
    chk_buf_write: assert property (eff && !req.is_read && req.pri == 4'h3
        |=> bufferability == $past(req.wdata))
        else $error("write buffer control not written");
    chk_cache_cmd_pulse: assert property (eff && !req.is_read && req.pri == 4'h7
        |=> cache_cmd.valid && cache_cmd.data == $past(req.wdata) ##1 !cache_cmd.valid)
        else $error("cache command not issued");
    chk_unassigned_zero: assert property (eff && req.is_read
        && req.pri inside {4'h4, 4'h8, 4'ha, 4'hb, 4'hc, 4'he} |=> rsp.rdata == 32'h0)
        else $error("unassigned read not zero");
    chk_cache_type_view: assert property (eff && req.is_read && req.pri == 4'h0
        && req.opc2 == 3'h1 |=> rsp.rdata == CACHE_TYPE)
        else $error("cache type view wrong");
    chk_endian_bit: assert property (eff && !req.is_read && req.pri == 4'h1
        |=> big_endian == $past(req.wdata[7]))
        else $error("endian output differs from control bit");
    chk_base_restore: assert property (s_armed_abort |=> s_restored)
        else $error("base not restored after abort");
    chk_reset_pins: assert property ($rose(reset_n) |=> system_control == {13'h0,
        $past(instr_memory_enable_init_pin), 4'h0, $past(high_vector_init_pin), 13'h0})
        else $error("control word wrong after reset");
endmodule // scc_coproc_properties

bind scc_coproc scc_coproc_properties #(.CACHE_TYPE(CACHE_TYPE)) u_props (.core_clk, .reset_n,
    .req, .rsp, .high_vector_init_pin, .instr_memory_enable_init_pin, .mem_instr_start,
    .mem_base_before, .data_abort, .base_restore_valid, .base_restore_value,
    .system_control, .big_endian, .bufferability, .cache_cmd);

// *** dv/scc_core_model.sv ***
/*
 behavioural core that issues coprocessor transfers and memory instructions.
 assumes it drives on the falling edge of core_clk and the block answers one cycle later.
*/
`timescale 1ns/10ps
module scc_core_model
    import scc_pkg::*;
(
    input wire logic core_clk,
    input wire scc_rsp_s rsp,
    output scc_req_s req,
    output logic mem_instr_start,
    output logic [31:0] mem_base_before,
    output logic mem_instr_done,
    output logic data_abort
);
    initial
    begin
        req = '0;
        mem_instr_start = 1'b0;
        mem_base_before = 32'h0;
        mem_instr_done = 1'b0;
        data_abort = 1'b0;
    end
    // flags are {is_reg_xfer, privileged, cond_pass, is_read}
    task automatic xfer(input logic [3:0] f, input logic [3:0] pri, input logic [3:0] sec,
                        input logic [2:0] opc2, input logic [31:0] wd, output scc_rsp_s r);
        @(negedge core_clk);
        req <= '{1'b1, f[3], f[0], f[1], f[2], 3'h0, pri, sec, opc2, wd};
        @(negedge core_clk);
        r = rsp;
        req.valid <= 1'b0;
        req.wdata <= ~req.wdata;
    endtask
    // one memory instruction, optionally without its start, ending in abort or done
    task automatic mem_op(input logic [31:0] base, input logic st, input logic ab);
        @(negedge core_clk);
        mem_instr_start <= st;
        mem_base_before <= base;
        @(negedge core_clk);
        mem_instr_start <= 1'b0;
        mem_base_before <= ~base;
        data_abort <= ab;
        mem_instr_done <= !ab;
        @(negedge core_clk);
        data_abort <= 1'b0;
        mem_instr_done <= 1'b0;
    endtask
endmodule // scc_core_model

// *** dv/tb.sv ***
/*
 self-checking bench for scc_coproc: register map, refusals, reset pins, abort restore.
 assumes scc_core_model issues all core traffic on the falling clock edge.
*/
`timescale 1ns/10ps
module tb;
    import scc_pkg::*;
    localparam logic [31:0] ID_VAL = 32'h0000_0c3a;  // arbitrary value
    localparam logic [31:0] CT_VAL = 32'h0e11_2233;
    localparam logic [31:0] MS_VAL = 32'h0000_4450;
    localparam logic [10:0] MAP [17] = '{{4'h1, 4'h0, 3'h0}, {4'h2, 4'h0, 3'h0},
        {4'h2, 4'h0, 3'h1}, {4'h3, 4'h0, 3'h0}, {4'h5, 4'h0, 3'h0}, {4'h5, 4'h0, 3'h1},
        {4'h6, 4'h0, 3'h0}, {4'h6, 4'h7, 3'h0}, {4'h9, 4'h0, 3'h0}, {4'h9, 4'h0, 3'h1},
        {4'h9, 4'h1, 3'h0}, {4'h9, 4'h1, 3'h1}, {4'hd, 4'h0, 3'h0}, {4'hf, 4'h1, 3'h0},
        {4'hf, 4'h0, 3'h0}, {4'hf, 4'h0, 3'h1}, {4'hf, 4'h1, 3'h1}};
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hv_pin = 1'b0;
    logic im_pin = 1'b0;
    scc_req_s req;
    scc_rsp_s rsp;
    scc_cache_cmd_s cache_cmd;
    logic mem_instr_start, mem_instr_done, data_abort, base_restore_valid, big_endian;
    logic [31:0] mem_base_before, base_restore_value, system_control, bufferability;
    logic [31:0] trace_context_id;
    logic [7:0][31:0] regions;
    int err_total = 0;
    int check_count = 0;
    always #12.5 core_clk = ~core_clk;
    scc_core_model core (.core_clk, .rsp, .req, .mem_instr_start, .mem_base_before,
        .mem_instr_done, .data_abort);
    scc_coproc #(.DEVICE_ID(ID_VAL), .CACHE_TYPE(CT_VAL), .LOCAL_MEM_SIZE(MS_VAL),
        .NUM_REGIONS(8)) uut (.core_clk, .reset_n, .req, .rsp, .high_vector_init_pin(hv_pin),
        .instr_memory_enable_init_pin(im_pin), .mem_instr_start, .mem_base_before,
        .mem_instr_done, .data_abort, .base_restore_valid, .base_restore_value,
        .system_control, .big_endian, .cacheability(), .bufferability, .permissions(),
        .regions, .way_lock(), .local_mem_region(), .trace_context_id, .memory_self_test(),
        .test_state(), .cache_debug_pointer(), .trace_control(), .cache_cmd);
    function automatic logic [31:0] wv(input int i);
        return {8'h5a, 8'(i), ~8'(i), 8'(i * 37) ^ 8'h80};
    endfunction
    task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_reset(input logic hv, input logic im);
        @(negedge core_clk);
        reset_n <= 1'b0;
        hv_pin <= hv;
        im_pin <= im;
        repeat (20) @(negedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(negedge core_clk);
        chk("control", {13'h0, im, 4'h0, hv, 13'h0}, system_control);
        chk("bufferable", 32'h0, bufferability);
        chk("trace id", 32'h0, trace_context_id);
    endtask
    task automatic t_rw();
        scc_rsp_s r;
        for (int i = 0; i < 17; i++)
            core.xfer(4'he, MAP[i][10:7], MAP[i][6:3], MAP[i][2:0], wv(i), r);
        chk("endian", 32'h1, {31'h0, big_endian});
        chk("buffer ctrl", wv(3), bufferability);
        chk("region 7", wv(7), regions[7]);
        chk("trace id", wv(12), trace_context_id);
        for (int i = 0; i < 17; i++)
        begin
            core.xfer(4'hf, MAP[i][10:7], MAP[i][6:3], MAP[i][2:0], 32'h0, r);
            chk("readback", wv(i), r.rdata);
            chk("readback trap", 32'h0, {31'h0, r.undef_trap});
        end
    endtask
    task automatic t_ident();
        scc_rsp_s r;
        for (int o = 0; o < 8; o++)
        begin
            core.xfer(4'hf, 4'h0, 4'h0, 3'(o), 32'h0, r);
            chk("ident view", o == 1 ? CT_VAL : o == 2 ? MS_VAL : ID_VAL, r.rdata);
        end
        core.xfer(4'he, 4'h0, 4'h0, 3'h0, 32'hffff_ffff, r);
        core.xfer(4'hf, 4'h0, 4'h0, 3'h0, 32'h0, r);
        chk("ident after write", ID_VAL, r.rdata);
    endtask
    task automatic t_undef();
        scc_rsp_s r;
        logic [3:0] ua [6] = '{4'h4, 4'h8, 4'ha, 4'hb, 4'hc, 4'he};
        for (int i = 0; i < 6; i++)
        begin
            core.xfer(4'he, ua[i], 4'h0, 3'h0, 32'hffff_ffff, r);
            core.xfer(4'hf, ua[i], 4'h0, 3'h0, 32'h0, r);
            chk("unassigned", 32'h0, r.rdata);
        end
        chk("buffer kept", wv(3), bufferability);
        core.xfer(4'he, 4'h7, 4'h5, 3'h2, 32'h1234_5678, r);
        chk("cache cmd", {1'b1, 4'h5, 3'h2, 24'h12_3456}, {cache_cmd.valid, cache_cmd.sec,
            cache_cmd.opc2, cache_cmd.data[31:8]});
        core.xfer(4'hf, 4'h7, 4'h0, 3'h0, 32'h0, r);
        chk("cache op read", 32'h0, r.rdata);
    endtask
    task automatic t_refuse();
        scc_rsp_s r;
        core.xfer(4'hf, 4'hd, 4'h0, 3'h0, 32'h0, r);
        core.xfer(4'hc, 4'h3, 4'h0, 3'h0, 32'h0bad_0001, r);
        chk("cond fail answer", 32'h2, {30'h0, r.valid, r.undef_trap});
        chk("cond fail write", wv(3), bufferability);
        core.xfer(4'hd, 4'h1, 4'h0, 3'h0, 32'h0, r);
        chk("cond fail read", wv(12), r.rdata);
        core.xfer(4'ha, 4'h3, 4'h0, 3'h0, 32'h0bad_0002, r);
        chk("user trap", 32'h1, {31'h0, r.undef_trap});
        core.xfer(4'h6, 4'h3, 4'h0, 3'h0, 32'h0bad_0003, r);
        chk("non transfer trap", 32'h1, {31'h0, r.undef_trap});
        chk("refused write", wv(3), bufferability);
    endtask
    task automatic t_abort();
        core.mem_op(32'h2000_0040, 1'b1, 1'b1);
        chk("restore", {1'b1, 32'h2000_0040}, {base_restore_valid, base_restore_value});
        core.mem_op(32'h3000_0080, 1'b1, 1'b0);
        chk("done quiet", {1'b0, 32'h2000_0040}, {base_restore_valid, base_restore_value});
        core.mem_op(32'h4000_00c0, 1'b0, 1'b1);
        chk("idle abort", 32'h0, {31'h0, base_restore_valid});
    endtask
    initial
    begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        results();
    end
    initial
    begin
        t_reset(1'b1, 1'b0);
        t_rw();
        t_ident();
        t_undef();
        t_refuse();
        t_abort();
        t_reset(1'b0, 1'b1);
        results();
    end
endmodule // tb
